//--- hdl/sbr_pkg.sv
/*
 * sbr_pkg: constants and types shared by the standby, reset-release and
 * boot-option sequencer.
 * Assumes a 100 MHz system clock and an AXI4-Lite register bus, 32-bit data.
 */
package sbr_pkg;

   // system clock
   localparam int CLK_PERIOD_NS = 10;

   // register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CONTROL = 8'h04;
   localparam logic [7:0] REG_BOOT_OPTION_BYTE = 8'h80;

   // program-memory address of the boot option byte
   localparam logic [15:0] BOOT_OPTION_ADDR = 16'h0080;

   // boot option byte field positions
   localparam int OPT_FIXED_HI_BIT = 7;
   localparam int OPT_SETTLE_HI_BIT = 6;
   localparam int OPT_SETTLE_LO_BIT = 5;
   localparam int OPT_FIXED_LO_BIT = 4;
   localparam int OPT_RESET_PIN_BIT = 3;
   localparam int OPT_CLKSRC_HI_BIT = 2;
   localparam int OPT_CLKSRC_LO_BIT = 1;
   localparam int OPT_SLOW_STOP_BIT = 0;

   // control register field positions
   localparam int CTL_SLOW_OSC_STOP_BIT = 0;
   localparam int CTL_WDT_SLOW_BIT = 1;
   localparam int CTL_AUX_TMR_SLOW_BIT = 2;

   // reset values
   localparam logic [7:0] OPT_RESET_VALUE = 8'h00;
   localparam logic [2:0] CTL_RESET_VALUE = 3'h0;

   // clock source codes
   localparam logic [1:0] CLKSRC_CRYSTAL = 2'h0;
   localparam logic [1:0] CLKSRC_EXTERNAL = 2'h1;

   // oscillation settle waits, system-clock cycles
   localparam int SETTLE_CYC_0 = 1024;
   localparam int SETTLE_CYC_1 = 4096;
   localparam int SETTLE_CYC_2 = 32768;
   localparam int SETTLE_CYC_3 = 131072;

   // option byte read stall, longest time rounded down
   localparam int OPT_READ_TIME_NS = 1074000;
   localparam int OPT_READ_CYC = OPT_READ_TIME_NS / CLK_PERIOD_NS;

   // wake waits after an interrupt release
   localparam int WAKE_VEC_CYC = 12;
   localparam int WAKE_RESUME_CYC = 4;

   localparam int CNT_W = 18;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_OPT_READ,
      ST_SETTLE,
      ST_RUN,
      ST_HALT,
      ST_STOP,
      ST_STOP_RST,
      ST_WAKE
   } sbr_state_t;

endpackage

//--- hdl/sbr_standby_ctrl.sv
/*
 * sbr_standby_ctrl: halt/stop standby control, reset release, supply-clear
 * gating and boot option byte decode, with an AXI4-Lite register slave.
 * Assumes cpu and interrupt inputs are on clk; reset pin and supply
 * comparator are asynchronous and synchronised here.
 */
// Chosen here: the AXI4-Lite interface to the registers.
// Function
// - halt instruction puts the device into the halt standby state.
// - halt stops cpu clock and execution; timers, converter, detector keep running.
// - port output latches hold their pre-standby values while halted.
// - an already pending unmasked request leaves standby at once.
// - slow-clock watchdog counts in halt unless software stopped that oscillator.
// - aux eight bit timer on slow clock stops in standby if oscillator stopped.
// - unmasked request releases halt; enable picks vectored or next instruction.
// - wait 11-13 clocks before vectoring, 3-5 clocks before plain resume.
// - reset during halt ends standby and runs a normal reset sequence.
// - after reset release, stall while reading the boot option byte.
// - reset in stop releases it after the oscillation settle time.
// - internal reset held while supply is under the clear threshold.
// - boot option byte sits at a fixed address with bits 7 and 4 set.
// - settle field picks 2^10, 2^12, 2^15 or 2^17 cycles.
// - settle wait only for the crystal source, none otherwise.
// - reset pin control bit: 1 reset input, 0 input-only port.
// - reset pin low before the option byte is read keeps reset.
// - clock source field: 00 crystal, 01 external, 1x internal oscillator.
// - crystal claims both oscillator pins, external only the input pin.
module sbr_standby_ctrl #(
   parameter int NUM_IRQ = 8,
   parameter int OPT_READ_CYCLES = sbr_pkg::OPT_READ_CYC,
   parameter int SETTLE_CYCLES_0 = sbr_pkg::SETTLE_CYC_0,
   parameter int SETTLE_CYCLES_1 = sbr_pkg::SETTLE_CYC_1,
   parameter int SETTLE_CYCLES_2 = sbr_pkg::SETTLE_CYC_2,
   parameter int SETTLE_CYCLES_3 = sbr_pkg::SETTLE_CYC_3
) (
   input wire logic clk,
   input wire logic reset_n,
   // cpu side
   input wire logic halt_exec,
   input wire logic stop_exec,
   input wire logic [NUM_IRQ-1:0] irq_request,
   input wire logic [NUM_IRQ-1:0] interrupt_mask_flag,
   input wire logic interrupt_accept_enable,
   output logic cpu_clk_en,
   output logic cpu_reset_active,
   output logic port_latch_hold,
   output logic wake_vectored,
   output logic wake_resume,
   // background functions
   output logic wdt_count_en,
   output logic aux_timer_count_en,
   // boot option byte fetch
   output logic opt_fetch_active,
   output logic [15:0] opt_fetch_addr,
   input wire logic [7:0] opt_byte_data,
   // clocking and pins
   output logic [1:0] clk_src_sel,
   output logic osc_in_pin_claim,
   output logic osc_out_pin_claim,
   input wire logic reset_pin_n,
   output logic reset_shared_input_port,
   input wire logic supply_above_threshold,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import sbr_pkg::*;

   // settle wait for a two-bit selection code
   function automatic logic [CNT_W-1:0] settle_cycles(input logic [1:0] code);
      logic [CNT_W-1:0] c;
      case (code)
         2'h0: c = CNT_W'(SETTLE_CYCLES_0);
         2'h1: c = CNT_W'(SETTLE_CYCLES_1);
         2'h2: c = CNT_W'(SETTLE_CYCLES_2);
         default: c = CNT_W'(SETTLE_CYCLES_3);
      endcase
      return c;
   endfunction

   // true when the slow oscillator is really stopped during standby
   function automatic logic slow_osc_dead(input logic [7:0] opt, input logic sw_stop);
      return !opt[OPT_SLOW_STOP_BIT] && sw_stop;
   endfunction

   // two-flop synchronisers for the reset pin and supply comparator
   logic pin_meta, pin_sync, sup_meta, sup_sync;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         sup_meta <= 1'b0;
         sup_sync <= 1'b0;
      end else begin
         pin_meta <= reset_pin_n;
         pin_sync <= pin_meta;
         sup_meta <= supply_above_threshold;
         sup_sync <= sup_meta;
      end
   end

   sbr_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [7:0] opt, next_opt;
   logic opt_loaded, next_opt_loaded;
   logic wake_vec, next_wake_vec;
   logic [2:0] ctl, next_ctl;
   logic next_wake_vectored, next_wake_resume;
   logic next_cpu_clk_en, next_cpu_reset_active, next_port_latch_hold;
   logic next_wdt_count_en, next_aux_timer_count_en, next_opt_fetch_active;
   logic [1:0] next_clk_src_sel;
   logic next_osc_in_pin_claim, next_osc_out_pin_claim, next_reset_shared_input_port;
   logic supply_low, pin_reset, wake_req, crystal, standby, slow_dead;

   // reset causes and release conditions
   always_comb begin
      supply_low = !sup_sync;
      // pin is reset until option read, then per control bit
      pin_reset = (!opt_loaded || opt[OPT_RESET_PIN_BIT]) && !pin_sync;
      // any request with mask flag clear wakes
      wake_req = |(irq_request & ~interrupt_mask_flag);
      crystal = (opt[OPT_CLKSRC_HI_BIT:OPT_CLKSRC_LO_BIT] == CLKSRC_CRYSTAL);
      standby = (next_state == ST_HALT) || (next_state == ST_STOP) || (next_state == ST_STOP_RST);
      slow_dead = slow_osc_dead(opt, ctl[CTL_SLOW_OSC_STOP_BIT]);
   end

   // sequencer next state
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_opt = opt;
      next_opt_loaded = opt_loaded;
      next_wake_vec = wake_vec;
      next_wake_vectored = 1'b0;
      next_wake_resume = 1'b0;
      case (state)
         ST_RESET: begin
            next_opt_loaded = 1'b0;
            if (!supply_low && !pin_reset) begin
               // stall while the option byte is read
               next_state = ST_OPT_READ;
               next_cnt = CNT_W'(OPT_READ_CYCLES);
            end
         end
         ST_OPT_READ: begin
            if (supply_low || pin_reset) begin
               // low pin before the read keeps reset
               next_state = ST_RESET;
            end else if (cnt <= CNT_W'(1)) begin
               // bits 7 and 4 forced to 1 whatever is programmed
               next_opt = opt_byte_data;
               next_opt[OPT_FIXED_HI_BIT] = 1'b1;
               next_opt[OPT_FIXED_LO_BIT] = 1'b1;
               next_opt_loaded = 1'b1;
               if (opt_byte_data[OPT_CLKSRC_HI_BIT:OPT_CLKSRC_LO_BIT] == CLKSRC_CRYSTAL) begin
                  // settle wait from the selection field
                  next_state = ST_SETTLE;
                  next_cnt = settle_cycles(opt_byte_data[OPT_SETTLE_HI_BIT:OPT_SETTLE_LO_BIT]);
               end else begin
                  next_state = ST_RUN;
               end
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         ST_SETTLE: begin
            if (supply_low || pin_reset) begin
               next_state = ST_RESET;
            end else if (cnt <= CNT_W'(1)) begin
               next_state = ST_RUN;
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         ST_RUN: begin
            if (supply_low || pin_reset) begin
               next_state = ST_RESET;
            end else if (halt_exec) begin
               next_state = ST_HALT;
            end else if (stop_exec) begin
               next_state = ST_STOP;
            end
         end
         ST_HALT: begin
            if (supply_low || pin_reset) begin
               next_state = ST_RESET;
            end else if (wake_req) begin
               next_state = ST_WAKE;
               next_wake_vec = interrupt_accept_enable;
               next_cnt = interrupt_accept_enable ? CNT_W'(WAKE_VEC_CYC) : CNT_W'(WAKE_RESUME_CYC);
            end
         end
         ST_STOP: begin
            if (supply_low) begin
               next_state = ST_RESET;
            end else if (pin_reset) begin
               next_state = ST_STOP_RST;
               next_cnt = crystal ? settle_cycles(opt[OPT_SETTLE_HI_BIT:OPT_SETTLE_LO_BIT]) : CNT_W'(1);
            end else if (wake_req) begin
               next_state = ST_WAKE;
               next_wake_vec = interrupt_accept_enable;
               next_cnt = interrupt_accept_enable ? CNT_W'(WAKE_VEC_CYC) : CNT_W'(WAKE_RESUME_CYC);
            end
         end
         ST_STOP_RST: begin
            // count the settle time, then reset
            if (supply_low || cnt <= CNT_W'(1)) begin
               next_state = ST_RESET;
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         ST_WAKE: begin
            if (supply_low || pin_reset) begin
               next_state = ST_RESET;
            end else if (cnt <= CNT_W'(1)) begin
               next_state = ST_RUN;
               next_wake_vectored = wake_vec;
               next_wake_resume = !wake_vec;
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
   end

   // registered outputs, decoded from the next state so they line up with it
   always_comb begin
      next_cpu_clk_en = (next_state == ST_RUN);
      next_cpu_reset_active = (next_state == ST_RESET) || (next_state == ST_OPT_READ) ||
                              (next_state == ST_SETTLE);
      // latches frozen through standby and the wake wait
      next_port_latch_hold = (next_state == ST_HALT) || (next_state == ST_STOP) ||
                             (next_state == ST_STOP_RST) || (next_state == ST_WAKE);
      next_opt_fetch_active = (next_state == ST_OPT_READ);
      // slow-clock watchdog runs once the option byte is loaded and stops then only if its oscillator is dead in standby
      next_wdt_count_en = ctl[CTL_WDT_SLOW_BIT] && next_opt_loaded && !(standby && slow_dead);
      // aux timer on slow clock halts likewise
      next_aux_timer_count_en = !(ctl[CTL_AUX_TMR_SLOW_BIT] && standby && slow_dead);
      next_clk_src_sel = next_opt[OPT_CLKSRC_HI_BIT:OPT_CLKSRC_LO_BIT];
      // claims follow the byte as it loads, so run never sees stale pins
      next_osc_in_pin_claim = next_opt_loaded && !next_opt[OPT_CLKSRC_HI_BIT];
      next_osc_out_pin_claim = next_opt_loaded && (next_opt[OPT_CLKSRC_HI_BIT:OPT_CLKSRC_LO_BIT] == CLKSRC_CRYSTAL);
      // pin level passed to the port when it is not a reset
      next_reset_shared_input_port = (next_opt_loaded && !next_opt[OPT_RESET_PIN_BIT]) ? pin_sync : 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_RESET;
         cnt <= '0;
         opt <= OPT_RESET_VALUE;
         opt_loaded <= 1'b0;
         wake_vec <= 1'b0;
         wake_vectored <= 1'b0;
         wake_resume <= 1'b0;
         cpu_clk_en <= 1'b0;
         cpu_reset_active <= 1'b1;
         port_latch_hold <= 1'b0;
         opt_fetch_active <= 1'b0;
         opt_fetch_addr <= BOOT_OPTION_ADDR;
         wdt_count_en <= 1'b0;
         aux_timer_count_en <= 1'b1;
         clk_src_sel <= OPT_RESET_VALUE[OPT_CLKSRC_HI_BIT:OPT_CLKSRC_LO_BIT];
         osc_in_pin_claim <= 1'b0;
         osc_out_pin_claim <= 1'b0;
         reset_shared_input_port <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         opt <= next_opt;
         opt_loaded <= next_opt_loaded;
         wake_vec <= next_wake_vec;
         wake_vectored <= next_wake_vectored;
         wake_resume <= next_wake_resume;
         cpu_clk_en <= next_cpu_clk_en;
         cpu_reset_active <= next_cpu_reset_active;
         port_latch_hold <= next_port_latch_hold;
         opt_fetch_active <= next_opt_fetch_active;
         opt_fetch_addr <= BOOT_OPTION_ADDR;
         wdt_count_en <= next_wdt_count_en;
         aux_timer_count_en <= next_aux_timer_count_en;
         clk_src_sel <= next_clk_src_sel;
         osc_in_pin_claim <= next_osc_in_pin_claim;
         osc_out_pin_claim <= next_osc_out_pin_claim;
         reset_shared_input_port <= next_reset_shared_input_port;
      end
   end

   // axi4-lite slave: write taken only with address and data both present,
   // which keeps one state bit per channel at the cost of a held channel
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_go, rd_go;

   always_comb begin
      wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      next_awready = wr_go;
      next_wready = wr_go;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_ctl = ctl;
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp = 2'h0;
         if (s_axi_awaddr == REG_CONTROL) begin
            if (s_axi_wstrb[0]) begin
               next_ctl = s_axi_wdata[2:0];
            end
         end else if (s_axi_awaddr != REG_STATUS && s_axi_awaddr != REG_BOOT_OPTION_BYTE) begin
            next_bresp = 2'h3; // unmapped
         end
      end
      next_arready = rd_go;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = 2'h0;
         case (s_axi_araddr)
            REG_STATUS: next_rdata = {27'h0, opt_loaded, 1'b0, 3'(state)};
            REG_CONTROL: next_rdata = {29'h0, ctl};
            REG_BOOT_OPTION_BYTE: next_rdata = {24'h0, opt};
            default: begin
               next_rdata = 32'h0;
               next_rresp = 2'h3;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl <= CTL_RESET_VALUE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         ctl <= next_ctl;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

endmodule

//--- sim/sbr_standby_ctrl_chk.sv
/*
 * sbr_chk: assertions on the standby, reset-release and boot-option ports.
 * Assumes it is bound to sbr_standby_ctrl and sees only its ports.
 */
module sbr_chk #(
   parameter int NUM_IRQ = 8,
   parameter int OPT_READ_CYCLES = 20,
   parameter int SETTLE_CYCLES_0 = 8,
   parameter int SETTLE_CYCLES_1 = 16,
   parameter int SETTLE_CYCLES_2 = 32,
   parameter int SETTLE_CYCLES_3 = 64
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic halt_exec,
   input wire logic [NUM_IRQ-1:0] irq_request,
   input wire logic [NUM_IRQ-1:0] interrupt_mask_flag,
   input wire logic interrupt_accept_enable,
   input wire logic cpu_clk_en,
   input wire logic cpu_reset_active,
   input wire logic port_latch_hold,
   input wire logic wake_vectored,
   input wire logic wake_resume,
   input wire logic opt_fetch_active,
   input wire logic [15:0] opt_fetch_addr,
   input wire logic [7:0] opt_byte_data,
   input wire logic [1:0] clk_src_sel,
   input wire logic osc_in_pin_claim,
   input wire logic osc_out_pin_claim,
   input wire logic reset_pin_n,
   input wire logic supply_above_threshold
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pend, start, waking;
   logic [7:0] opt_cap;
   int fetch_cnt, settle_cnt, exp_settle;
   // start marks the first standby cycle that sees an unmasked request
   assign pend = |(irq_request & ~interrupt_mask_flag);
   assign start = port_latch_hold && pend && !waking;
   assign exp_settle = (opt_cap[2:1] != 2'h0) ? 0 : (opt_cap[6:5] == 2'h0) ? SETTLE_CYCLES_0 :
      (opt_cap[6:5] == 2'h1) ? SETTLE_CYCLES_1 : (opt_cap[6:5] == 2'h2) ? SETTLE_CYCLES_2 : SETTLE_CYCLES_3;
   // counters of stall and settle cycles, captured option byte
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         waking <= 1'h0;
         opt_cap <= 8'h00;
         fetch_cnt <= 0;
         settle_cnt <= 0;
      end else begin
         waking <= port_latch_hold && !(wake_vectored || wake_resume) && (waking || start);
         if (opt_fetch_active) opt_cap <= opt_byte_data;
         fetch_cnt <= opt_fetch_active ? fetch_cnt + 1 : 0;
         settle_cnt <= opt_fetch_active ? 0 : settle_cnt + int'(cpu_reset_active);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_halt_entry;
      halt_exec && cpu_clk_en |=> !cpu_clk_en && port_latch_hold;
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");
   property p_clk_gate;
      port_latch_hold |-> !cpu_clk_en && !cpu_reset_active;
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("cpu clock runs in standby");
   property p_vec_wait;
      start && interrupt_accept_enable |-> ##1 !wake_vectored[*8] ##[3:6] wake_vectored;
   endproperty
   a_vec_wait: assert property (p_vec_wait) else $error("vectored wake wait wrong");
   property p_res_wait;
      start && !interrupt_accept_enable |-> ##1 !wake_resume[*2] ##[1:4] wake_resume;
   endproperty
   a_res_wait: assert property (p_res_wait) else $error("resume wake wait wrong");
   property p_masked_hold;
      port_latch_hold && !pend && !waking && supply_above_threshold && reset_pin_n |=> port_latch_hold;
   endproperty
   a_masked_hold: assert property (p_masked_hold) else $error("standby left without request");
   property p_fetch;
      opt_fetch_active |-> cpu_reset_active && !cpu_clk_en && opt_fetch_addr == 16'h0080;
   endproperty
   a_fetch: assert property (p_fetch) else $error("option fetch while running");
   property p_fetch_len;
      $fell(opt_fetch_active) |-> fetch_cnt == OPT_READ_CYCLES;
   endproperty
   a_fetch_len: assert property (p_fetch_len) else $error("option stall length wrong");
   property p_settle;
      $fell(cpu_reset_active) |-> settle_cnt >= exp_settle && settle_cnt <= exp_settle + 1;
   endproperty
   a_settle: assert property (p_settle) else $error("settle wait wrong");
   property p_pins;
      cpu_clk_en |-> clk_src_sel == opt_cap[2:1] && osc_in_pin_claim == !opt_cap[2] &&
         osc_out_pin_claim == (opt_cap[2:1] == 2'h0);
   endproperty
   a_pins: assert property (p_pins) else $error("clock source or pin claim wrong");
   property p_supply;
      !supply_above_threshold [*6] |-> cpu_reset_active;
   endproperty
   a_supply: assert property (p_supply) else $error("no reset on low supply");
endmodule

bind sbr_standby_ctrl sbr_chk #(.NUM_IRQ(NUM_IRQ), .OPT_READ_CYCLES(OPT_READ_CYCLES),
   .SETTLE_CYCLES_0(SETTLE_CYCLES_0), .SETTLE_CYCLES_1(SETTLE_CYCLES_1),
   .SETTLE_CYCLES_2(SETTLE_CYCLES_2), .SETTLE_CYCLES_3(SETTLE_CYCLES_3)) sbr_chk_inst (.*);

//--- sim/sbr_opt_mem.sv
/*
 * sbr_opt_mem: program memory holding the boot option byte.
 * Assumes the sequencer drives fetch address and strobe on clk.
 */
module sbr_opt_mem (
   input wire logic opt_fetch_active,
   input wire logic [15:0] opt_fetch_addr,
   input wire logic [7:0] opt_value,
   output logic [7:0] opt_byte_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // fixed address, bits 7 and 4 set; inverse when not addressed
   assign opt_byte_data = (opt_fetch_active && opt_fetch_addr == 16'h0080) ? (opt_value | 8'h90) : ~(opt_value | 8'h90);
endmodule

//--- sim/sbr_standby_ctrl_test.sv
/*
 * sbr_standby_ctrl_test: directed bench for the standby and boot sequencer.
 * Assumes small stall and settle counts given as parameters.
 */
module sbr_standby_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sbr_pkg::*;
   localparam logic [7:0] OPTS [8] = '{8'h68, 8'h0a, 8'h08, 8'h29, 8'h25, 8'h40, 8'h4e, 8'h7f};
   logic clk = 1'h0, reset_n = 1'h0, halt_exec = 1'h0, stop_exec = 1'h0, interrupt_accept_enable = 1'h0;
   logic reset_pin_n = 1'h0, supply_above_threshold = 1'h1, cpu_clk_en, cpu_reset_active, port_latch_hold;
   logic wake_vectored, wake_resume, wdt_count_en, aux_timer_count_en, opt_fetch_active;
   logic osc_in_pin_claim, osc_out_pin_claim, reset_shared_input_port;
   logic [7:0] irq_request = 8'h00, interrupt_mask_flag = 8'hff, opt_byte_data, opt_value = 8'h00;
   logic [15:0] opt_fetch_addr;
   logic [1:0] clk_src_sel, s_axi_bresp, s_axi_rresp;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int n_errors = 0, tests_run = 0;

   sbr_standby_ctrl #(.OPT_READ_CYCLES(20), .SETTLE_CYCLES_0(8), .SETTLE_CYCLES_1(16), .SETTLE_CYCLES_2(32),
      .SETTLE_CYCLES_3(64)) sbr_standby_ctrl_inst (.*);
   sbr_opt_mem sbr_opt_mem_inst (.opt_fetch_active, .opt_fetch_addr, .opt_value, .opt_byte_data);

   // 100 MHz clock
   always #5 clk = ~clk;

   task chk(input logic [31:0] v, input logic [31:0] e);
      tests_run++;
      if (v !== e) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, v, e);
      end
   endtask

   task print_verdict;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask

   task wait_run;
      do @(posedge clk); while (cpu_clk_en !== 1'h1);
   endtask

   // write: address and data offered together, each released when taken
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, r);
   endtask

   task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask

   // full reset with the pin held low past release, then boot
   task boot(input logic [7:0] v);
      @(posedge clk);
      opt_value <= v;
      reset_n <= 1'h0;
      reset_pin_n <= 1'h0;
      tick(3);
      reset_n <= 1'h1;
      tick(10);
      chk(cpu_reset_active, 1'h1);
      chk(opt_fetch_active, 1'h0);
      reset_pin_n <= 1'h1;
      wait_run;
      axi_rd(REG_BOOT_OPTION_BYTE, {24'h0, v | 8'h90}, 2'h0);
      axi_rd(REG_STATUS, 32'h13, 2'h0);
      chk(clk_src_sel, v[2:1]);
      chk(osc_in_pin_claim, !v[2]);
      chk(osc_out_pin_claim, v[2:1] == 2'h0);
      chk(reset_shared_input_port, 1'h1);
      if (!v[3]) begin
         reset_pin_n <= 1'h0;
         tick(6);
         chk(reset_shared_input_port, 1'h0);
         chk(cpu_clk_en, 1'h1);
         reset_pin_n <= 1'h1;
      end
   endtask

   // enter halt or stop, hold with a masked request unless pre leaves it pending, then wake
   task standby(input logic stp, input logic en, input logic pre, input logic cnt);
      int n;
      irq_request <= 8'h04;
      interrupt_mask_flag <= pre ? 8'hfb : 8'hff;
      interrupt_accept_enable <= en;
      @(posedge clk);
      halt_exec <= !stp;
      stop_exec <= stp;
      @(posedge clk);
      halt_exec <= 1'h0;
      stop_exec <= 1'h0;
      if (!pre) begin
         tick(6);
         chk(port_latch_hold, 1'h1);
         chk(cpu_clk_en, 1'h0);
         axi_rd(REG_STATUS, 32'h14 + stp, 2'h0);
         if (!stp) chk(wdt_count_en, cnt);
         if (!stp) chk(aux_timer_count_en, cnt);
         interrupt_mask_flag <= 8'hfb;
      end
      @(posedge clk);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((en ? wake_vectored : wake_resume) !== 1'h1);
      chk(n >= (en ? 11 : 3) && n <= (en ? 14 : 6), 1'h1);
      irq_request <= 8'h00;
      interrupt_mask_flag <= 8'hff;
   endtask

   // main sequence: each of the eight option bytes in OPTS, then reset sources
   initial begin
      logic ctl0;
      for (int i = 0; i < 8; i++) begin
         boot(OPTS[i]);
         ctl0 = i[1] ^ i[2];
         axi_rd(REG_CONTROL, 32'h0, 2'h0);
         axi_wr(REG_CONTROL, {29'h0, 2'h3, ctl0}, 2'h0);
         axi_rd(REG_CONTROL, {29'h0, 2'h3, ctl0}, 2'h0);
         standby(i[0], i[1], i[2], !(ctl0 && !OPTS[i][0]));
      end
      boot(8'h68);
      axi_wr(REG_BOOT_OPTION_BYTE, 32'h0, 2'h0);
      axi_rd(REG_BOOT_OPTION_BYTE, 32'hf8, 2'h0);
      axi_wr(8'h40, 32'h1, 2'h3);
      axi_rd(8'h40, 32'h0, 2'h3);
      supply_above_threshold <= 1'h0;
      tick(8);
      chk(cpu_reset_active, 1'h1);
      supply_above_threshold <= 1'h1;
      wait_run;
      halt_exec <= 1'h1;
      @(posedge clk);
      halt_exec <= 1'h0;
      tick(3);
      reset_pin_n <= 1'h0;
      tick(8);
      chk(cpu_reset_active, 1'h1);
      chk(port_latch_hold, 1'h0);
      reset_pin_n <= 1'h1;
      wait_run;
      axi_rd(REG_STATUS, 32'h13, 2'h0);
      stop_exec <= 1'h1;
      @(posedge clk);
      stop_exec <= 1'h0;
      tick(3);
      reset_pin_n <= 1'h0;
      tick(20);
      chk(port_latch_hold, 1'h1);
      chk(cpu_reset_active, 1'h0);
      tick(70);
      chk(cpu_reset_active, 1'h1);
      reset_pin_n <= 1'h1;
      wait_run;
      print_verdict;
   end

   // watchdog, several times the expected run length
   initial begin
      #200000;
      n_errors++;
      print_verdict;
   end
endmodule
